// ### bench/testbench.sv
`timescale 1ns/1ns
module testbench;
  import vcfr_pkg::*;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  localparam int EV = 200;
  localparam int MO = 60;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic supply_above_turn_on_i = 1'b0, ring_slow_sel_i = 1'b0, line_high_i = 1'b0;
  logic [1:0] feedback_level_above_up_i = 2'h0, feedback_level_above_down_i = 2'h0;
  logic feedback_level_above_reset_i = 1'b0, ring_en = 1'b1;
  logic valley_detect_input_i, switch_off_i, gate_drive_o, charge_cell_en_o;
  logic [9:0] cs_limit_mv_o;
  logic [2:0] valley_count_o;
  logic [31:0] d;
  logic [1:0] r;
  int num_errors = 0, compares = 0, seed = 5217, cyc = 0;
  int mv, prev, lvl, n, tm;

  // Clock and free cycle count, counted by NBA so readers see the old value
  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc <= cyc + 1;

  vcfr_top #(.EVAL_CYCLES(EV), .SS_STEP_CYCLES(50), .MAX_OFF_CYCLES(MO),
    .RING_LONG_CYCLES(8), .RING_SHORT_CYCLES(3)) vcfr_top_inst (
    .mclk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .supply_above_turn_on_i, .valley_detect_input_i,
    .ring_slow_sel_i, .line_high_i, .feedback_level_above_up_i, .feedback_level_above_down_i,
    .feedback_level_above_reset_i, .switch_off_i, .gate_drive_o, .charge_cell_en_o,
    .cs_limit_mv_o, .valley_count_o);

  vcfr_partner vcfr_partner_inst (.mclk_i(mclk_i), .gate_i(gate_drive_o), .ring_en_i(ring_en),
    .valley_o(valley_detect_input_i), .switch_off_o(switch_off_i));

  // ----------------------------------------
  // Tasks and reference model
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Both channels offered together, bready held until the response
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    int t;
    t = 0;
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      t++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && t < 100);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    check(32'(t < 100), 32'h1);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    int t;
    t = 0;
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk_i);
      t++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && t < 100);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    check(32'(t < 100), 32'h1);
  endtask : axi_rd

  // Level 0 below up, 1 above up, 2 above down, 3 above reset; other pair held low
  task automatic set_fb(input int l);
    logic ln;
    ln = 1'($random(seed));
    line_high_i <= ln;
    feedback_level_above_up_i <= (l >= 1) ? (ln ? 2'h2 : 2'h1) : 2'h0;
    feedback_level_above_down_i <= (l >= 2) ? (ln ? 2'h2 : 2'h1) : 2'h0;
    feedback_level_above_reset_i <= (l == 3);
    ring_slow_sel_i <= 1'($random(seed));
  endtask : set_fb

  function automatic int next_valley(input int v, input int l);
    case (l)
      0: return (v < 7) ? v + 1 : 7;
      1: return v;
      2: return (v > 1) ? v - 1 : 1;
      default: return 1;
    endcase
  endfunction : next_valley

  task automatic results();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    check(32'(cs_limit_mv_o), 32'h140);
    check(32'(valley_count_o), 32'h1);
    check(32'(charge_cell_en_o), 32'h1);
    axi_rd(OFS_CTRL, d, r);
    check(d, CTRL_RST);
    axi_rd(8'h40, d, r);
    check({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    axi_wr(8'h40, 32'h1, r);
    check(32'(r), 32'(RESP_SLVERR));
    axi_wr(OFS_CTRL, 32'h0, r);
    axi_rd(OFS_CTRL, d, r);
    check(d, 32'h0);
    axi_wr(OFS_CTRL, 32'h1, r);
    axi_wr(OFS_LIMIT, 32'h0, r);
    check(32'(r), 32'(RESP_OKAY));
    axi_rd(OFS_LIMIT, d, r);
    check({r, d[29:0]}, {RESP_OKAY, 30'h140});
    // Supply up: first decision marks the period grid
    @(posedge mclk_i);
    supply_above_turn_on_i <= 1'b1;
    n = 0;
    while (valley_count_o !== 3'h2 && n < 2 * EV) begin
      @(posedge mclk_i);
      n++;
    end
    check(32'(n >= EV && n <= EV + 6), 32'h1);
    mv = 2;
    prev = 0;
    tm = cyc + EV / 2;
    for (int k = 0; k < 20; k++) begin
      while (cyc < tm + k * EV) @(posedge mclk_i);
      check(32'(valley_count_o), 32'(mv));
      if (k == 0) check(32'(cs_limit_mv_o), 32'h3e8);
      if (k == 6) begin
        while (gate_drive_o !== 1'b1) @(posedge mclk_i);
        while (gate_drive_o !== 1'b0) @(posedge mclk_i);
        n = 0;
        while (gate_drive_o !== 1'b1 && n < 100) begin
          @(posedge mclk_i);
          n++;
        end
        check(32'(n >= 40 && n <= 50), 32'h1);
      end
      if (k == 9) begin
        axi_rd(OFS_STATUS, d, r);
        check({d[15], d[13], 1'b0, d[2:0]}, {3'h2, 3'(mv)});
      end
      lvl = (k < 7) ? 0 : (k < 11) ? k - 7 : $unsigned($random(seed)) % 4;
      set_fb(lvl);
      mv = next_valley(mv, (lvl > prev) ? lvl : prev);
      prev = lvl;
      // Damped ring: only the off-time limit can turn the switch on
      // Done after the level is set, so the period boundary is not delayed
      if (k == 12) begin
        ring_en <= 1'b0;
        while (gate_drive_o !== 1'b1) @(posedge mclk_i);
        while (gate_drive_o !== 1'b0) @(posedge mclk_i);
        n = 0;
        while (gate_drive_o !== 1'b1 && n < 100) begin
          @(posedge mclk_i);
          n++;
        end
        check(32'(n), 32'(MO));
        ring_en <= 1'b1;
      end
    end
    // Supply loss: back to charging with counters at start values
    supply_above_turn_on_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    check(32'({charge_cell_en_o, gate_drive_o, valley_count_o}), 32'h11);
    check(32'(cs_limit_mv_o), 32'h140);
    results();
  end

  // Watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    results();
  end
endmodule : testbench

// ### bench/vcfr_monitor.sv
`timescale 1ns/1ns
module vcfr_monitor #(
  parameter int MAX_OFF_CYCLES = 500
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Comparator inputs
  input wire logic supply_above_turn_on_i,
  input wire logic feedback_level_above_reset_i,
  input wire logic switch_off_i,
  // Driver side outputs
  input wire logic gate_drive_o,
  input wire logic charge_cell_en_o,
  input wire logic [9:0] cs_limit_mv_o,
  input wire logic [2:0] valley_count_o
);
  // ----------------------------------------
  // Switching and counter checks
  // ----------------------------------------
  // Slack of a few cycles for synchroniser and decision edge
  localparam int OFF_LIM = MAX_OFF_CYCLES + 4;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Requests held long enough to cross the two-flop synchroniser
  sequence supply_held; supply_above_turn_on_i [*3]; endsequence
  sequence off_req; switch_off_i [*3]; endsequence
  sequence gate_off; $fell(gate_drive_o); endsequence

  valley_range_a: assert property (valley_count_o != 3'h0)
    else $error("valley count left its range");
  reset_state_a: assert property (@(posedge mclk_i) disable iff (1'b0) !rst_n_i |=>
    valley_count_o == 3'h1 && charge_cell_en_o && cs_limit_mv_o == 10'h140)
    else $error("wrong state after reset");
  valley_step_a: assert property ($changed(valley_count_o) && valley_count_o != 3'h1 |->
    valley_count_o == $past(valley_count_o) + 3'h1 ||
    valley_count_o == $past(valley_count_o) - 3'h1)
    else $error("valley count jumped");
  reset_force_a: assert property (feedback_level_above_reset_i |-> ##3 valley_count_o == 3'h1)
    else $error("reset level did not force valley one");
  limit_levels_a: assert property (cs_limit_mv_o inside {10'h140, 10'h1ea, 10'h294, 10'h33e,
    10'h3e8})
    else $error("current limit off its steps");
  limit_climb_a: assert property ($changed(cs_limit_mv_o) && cs_limit_mv_o != 10'h140 |->
    cs_limit_mv_o == $past(cs_limit_mv_o) + 10'h0aa)
    else $error("current limit skipped a step");
  charge_gate_a: assert property (charge_cell_en_o |-> !gate_drive_o)
    else $error("gate on while charging");
  supply_on_a: assert property (supply_held |=> !charge_cell_en_o)
    else $error("charging cell stayed on");
  ring_quiet_a: assert property (gate_off |-> !gate_drive_o [*3])
    else $error("turn-on during ringing suppression");
  max_off_a: assert property (gate_off |-> ##[1:OFF_LIM] (gate_drive_o || charge_cell_en_o))
    else $error("off time exceeded its limit");
  switch_off_a: assert property (off_req |=> !gate_drive_o)
    else $error("gate ignored turn-off request");
endmodule : vcfr_monitor

bind vcfr_top vcfr_monitor #(.MAX_OFF_CYCLES(MAX_OFF_CYCLES)) vcfr_monitor_inst (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .supply_above_turn_on_i(supply_above_turn_on_i),
  .feedback_level_above_reset_i(feedback_level_above_reset_i), .switch_off_i(switch_off_i),
  .gate_drive_o(gate_drive_o), .charge_cell_en_o(charge_cell_en_o),
  .cs_limit_mv_o(cs_limit_mv_o), .valley_count_o(valley_count_o)
);

// ### bench/vcfr_partner.sv
`timescale 1ns/1ns
module vcfr_partner (
  // Clock
  input wire logic mclk_i,
  // Gate drive and test control
  input wire logic gate_i,
  input wire logic ring_en_i,
  // Comparator outputs
  output logic valley_o,
  output logic switch_off_o
);
  // ----------------------------------------
  // Current sense and ringing model
  // ----------------------------------------
  int cnt = 0;
  logic gate_q = 1'b0;
  // Phase restarts at every gate edge
  always @(posedge mclk_i) begin
    gate_q <= gate_i;
    cnt <= (gate_i != gate_q) ? 1 : cnt + 1;
  end
  // Peak current reached a few cycles into the on time; the registered gate
  // keeps the stale off-phase count from glitching a request at turn-on
  assign switch_off_o = gate_i && gate_q && cnt >= 4;
  // Ringing: one falling crossing every 6 cycles; damped ring gives none
  assign valley_o = !gate_i && ring_en_i && (cnt % 6) < 3;
endmodule : vcfr_partner

// ### rtl/vcfr_pkg.sv
// How it works
// R1: Judge feedback every 48ms, update at end
// R2: Always below up level: count up, max 7
// R3: Above up, never above down: hold
// R4: Above down, never above reset: count down
// R5: Above reset level: force count to 1
// R6: Valley count stays between 1 and 7
// R7: Valley count starts at 1
// R8: Line level input picks threshold set
// R9: Soft-start lasts 12ms in 4 steps
// R10: Current limit climbs 0.32V up to 1V
// R11: Supply on: charging cell off, start switching
// R12: Turn-on digital, turn-off from analog compare
// R13: Valley count picks the turn-on crossing
// R14: Crossing count 0..7, cleared at turn-on
// R15: After suppression, turn on at count reached
// R16: Max off time forces turn-on
// R17: Prescalers from one clock, inputs synchronised (line_high_i is used without the synchroniser)
package vcfr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int EVAL_PERIOD_MS = 48;
  localparam int EVAL_CYCLES = EVAL_PERIOD_MS * (CLK_HZ / 1000);
  localparam int SS_TOTAL_MS = 12;
  localparam int SS_STEPS = 4;
  localparam int SS_STEP_CYCLES = SS_TOTAL_MS * (CLK_HZ / 1000) / SS_STEPS;
  // Off-time limits, longest times round down
  localparam int MAX_OFF_US = 50;
  localparam int MAX_OFF_CYCLES = MAX_OFF_US * CLK_MHZ;
  // Ringing suppression, least times round up
  localparam int RING_LONG_NS = 3000;
  localparam int RING_SHORT_NS = 1000;
  localparam int RING_LONG_CYCLES = (RING_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int RING_SHORT_CYCLES = (RING_SHORT_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Counters and current limit levels (mV)
  // ----------------------------------------------------------------
  localparam logic [2:0] VALLEY_MIN = 3'h1;
  localparam logic [2:0] VALLEY_MAX = 3'h7;
  localparam logic [2:0] CROSS_MAX = 3'h7;
  localparam logic [2:0] SS_LAST_LEVEL = 3'h4;
  localparam logic [9:0] LIM_START_MV = 10'h140;
  localparam logic [9:0] LIM_END_MV = 10'h3e8;
  localparam logic [9:0] LIM_STEP_MV = (LIM_END_MV - LIM_START_MV) / 10'h4;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LIMIT = 8'h08;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int CTRL_EN_BIT = 0;
  localparam int ST_VALLEY_LSB = 0;
  localparam int ST_CROSS_LSB = 4;
  localparam int ST_LEVEL_LSB = 8;
  localparam int ST_SSDONE_BIT = 12;
  localparam int ST_RUN_BIT = 13;
  localparam int ST_GATE_BIT = 14;
  localparam int ST_CHARGE_BIT = 15;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Synchronised input vector positions
  localparam int IN_W = 9;
  localparam int IN_SUPPLY = 0;
  localparam int IN_VALLEY = 1;
  localparam int IN_RING_SLOW = 2;
  localparam int IN_UP_LO = 3;
  localparam int IN_UP_HI = 4;
  localparam int IN_DN_LO = 5;
  localparam int IN_DN_HI = 6;
  localparam int IN_RESET = 7;
  localparam int IN_OFF = 8;

  // ----------------------------------------------------------------
  // Switching state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_CHARGE = 2'b00,
    ST_ON = 2'b01,
    ST_SUPPRESS = 2'b10,
    ST_WAIT = 2'b11
  } vcfr_state_t;

endpackage : vcfr_pkg

// ### rtl/vcfr_sync.sv
`timescale 1ns/1ns
module vcfr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // ----------------------------------------------------------------
  // Two-flop synchroniser per bit
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta;
      // First flop is read only by the second
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          meta <= 1'b0;
          q_o[g] <= 1'b0;
        end else begin
          meta <= d_i[g];
          q_o[g] <= meta;
        end
      end
    end
  endgenerate

endmodule : vcfr_sync

// ### rtl/vcfr_top.sv
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
module vcfr_top #(
  parameter int EVAL_CYCLES = vcfr_pkg::EVAL_CYCLES,
  parameter int SS_STEP_CYCLES = vcfr_pkg::SS_STEP_CYCLES,
  parameter int MAX_OFF_CYCLES = vcfr_pkg::MAX_OFF_CYCLES,
  parameter int RING_LONG_CYCLES = vcfr_pkg::RING_LONG_CYCLES,
  parameter int RING_SHORT_CYCLES = vcfr_pkg::RING_SHORT_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog comparators
  input wire logic supply_above_turn_on_i,
  input wire logic valley_detect_input_i,
  input wire logic ring_slow_sel_i,
  input wire logic line_high_i,
  input wire logic [1:0] feedback_level_above_up_i,
  input wire logic [1:0] feedback_level_above_down_i,
  input wire logic feedback_level_above_reset_i,
  input wire logic switch_off_i,
  // Gate driver, start-up cell, current limit
  output logic gate_drive_o,
  output logic charge_cell_en_o,
  output logic [9:0] cs_limit_mv_o,
  output logic [2:0] valley_count_o
);
  import vcfr_pkg::*;

  localparam int EVAL_W = $clog2(EVAL_CYCLES + 1);
  localparam int SS_W = $clog2(SS_STEP_CYCLES + 1);
  localparam int OFF_W = $clog2(MAX_OFF_CYCLES + RING_LONG_CYCLES + 1);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [IN_W-1:0] raw_in;
  logic [IN_W-1:0] syn;

  // Line level chooses which comparator pair is meaningful
  assign raw_in = {switch_off_i, feedback_level_above_reset_i,
                   feedback_level_above_down_i, feedback_level_above_up_i,
                   ring_slow_sel_i, valley_detect_input_i, supply_above_turn_on_i};

  vcfr_sync #(.W(IN_W)) u_sync ( // [R17]
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i(raw_in),
    .q_o(syn)
  );

  logic supply_ok;
  logic above_up;
  logic above_down;
  logic above_reset;
  logic valley_prev;
  logic valley_fall;

  assign supply_ok = syn[IN_SUPPLY];
  assign above_up = line_high_i ? syn[IN_UP_HI] : syn[IN_UP_LO]; // [R8]
  assign above_down = line_high_i ? syn[IN_DN_HI] : syn[IN_DN_LO]; // [R8]
  assign above_reset = syn[IN_RESET];

  // Falling edge of the crossing comparator, taken after the synchroniser
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      valley_prev <= 1'b0;
    end else begin
      valley_prev <= syn[IN_VALLEY];
    end
  end
  assign valley_fall = valley_prev && !syn[IN_VALLEY];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic switch_en;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  assign switch_en = ctrl[CTRL_EN_BIT];
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // Address and data are taken in either order
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write commit and response; only the control word is writable
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctrl <= CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr[7:2] == OFS_CTRL[7:2]) begin
        s_axi_bresp <= RESP_OKAY;
        if (w_strb[0]) begin
          ctrl[CTRL_EN_BIT] <= w_data[CTRL_EN_BIT];
        end
      end else if (aw_addr[7:2] == OFS_STATUS[7:2] || aw_addr[7:2] == OFS_LIMIT[7:2]) begin
        s_axi_bresp <= RESP_OKAY; // Read-only, write ignored
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Switching state machine
  // ----------------------------------------------------------------
  vcfr_state_t state;
  vcfr_state_t next_state;
  logic [OFF_W-1:0] off_timer;
  logic [2:0] cross_count;
  logic [2:0] valley;
  logic [OFF_W-1:0] ring_end;
  logic off_max;
  logic ring_done;
  logic running;

  assign running = (state != ST_CHARGE);
  assign ring_end = syn[IN_RING_SLOW] ? OFF_W'(RING_LONG_CYCLES - 1)
                                      : OFF_W'(RING_SHORT_CYCLES - 1);
  assign ring_done = off_timer >= ring_end;
  assign off_max = off_timer >= OFF_W'(MAX_OFF_CYCLES - 1);

  // Turn-off is the analog compare; turn-on is decided here
  always_comb begin
    next_state = state;
    unique case (state)
      ST_CHARGE: begin
        if (supply_ok) begin
          next_state = ST_SUPPRESS; // [R11]
        end
      end
      ST_SUPPRESS: begin
        if (switch_en && off_max) begin
          next_state = ST_ON; // [R16]
        end else if (ring_done) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (switch_en && (off_max || cross_count >= valley)) begin
          next_state = ST_ON; // [R13] [R15] [R16]
        end
      end
      ST_ON: begin
        if (syn[IN_OFF] || !switch_en) begin
          next_state = ST_SUPPRESS; // [R12]
        end
      end
    endcase
    if (!supply_ok) begin
      next_state = ST_CHARGE;
    end
  end

  // State, gate and charging cell all registered
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state <= ST_CHARGE;
      gate_drive_o <= 1'b0;
      charge_cell_en_o <= 1'b1;
    end else begin
      state <= next_state;
      gate_drive_o <= (next_state == ST_ON);
      charge_cell_en_o <= (next_state == ST_CHARGE); // [R11]
    end
  end

  // Off-time timer, saturating so a long stall cannot wrap
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      off_timer <= '0;
    end else if (state == ST_ON || state == ST_CHARGE) begin
      off_timer <= '0;
    end else if (!off_max) begin
      off_timer <= off_timer + OFF_W'(1);
    end
  end

  // Crossing counter, counts only while the switch is off
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cross_count <= '0;
    end else if (state == ST_ON || state == ST_CHARGE) begin
      cross_count <= '0; // [R14]
    end else if (valley_fall && cross_count != CROSS_MAX) begin
      cross_count <= cross_count + 3'h1; // [R14]
    end
  end

  // ----------------------------------------------------------------
  // Valley count update
  // ----------------------------------------------------------------
  logic [EVAL_W-1:0] eval_cnt;
  logic eval_end;
  logic seen_up;
  logic seen_down;
  logic seen_up_now;
  logic seen_down_now;

  assign eval_end = running && (eval_cnt == EVAL_W'(EVAL_CYCLES - 1));
  assign seen_up_now = seen_up || above_up;
  assign seen_down_now = seen_down || above_down;

  // Evaluation prescaler from the main clock
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !running) begin
      eval_cnt <= '0;
    end else if (eval_end) begin
      eval_cnt <= '0; // [R1] [R17]
    end else begin
      eval_cnt <= eval_cnt + EVAL_W'(1);
    end
  end

  // Threshold history; the sample at the boundary opens the next period
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !running) begin
      seen_up <= 1'b0;
      seen_down <= 1'b0;
    end else if (eval_end) begin
      seen_up <= above_up;
      seen_down <= above_down;
    end else begin
      seen_up <= seen_up_now;
      seen_down <= seen_down_now;
    end
  end

  // Reset level acts at once, not at the boundary, for fast load steps
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !running) begin
      valley <= VALLEY_MIN; // [R7]
    end else if (above_reset) begin
      valley <= VALLEY_MIN; // [R5]
    end else if (eval_end) begin
      if (seen_down_now) begin
        if (valley != VALLEY_MIN) begin
          valley <= valley - 3'h1; // [R4] [R6]
        end
      end else if (!seen_up_now) begin
        if (valley != VALLEY_MAX) begin
          valley <= valley + 3'h1; // [R2] [R6]
        end
      end else begin
        valley <= valley; // [R3]
      end
    end
  end
  assign valley_count_o = valley;

  // ----------------------------------------------------------------
  // Soft-start
  // ----------------------------------------------------------------
  logic [SS_W-1:0] ss_cnt;
  logic [2:0] ss_level;
  logic ss_done;

  assign ss_done = (ss_level == SS_LAST_LEVEL);

  // Step prescaler; level 4 is the final 1V limit
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !running) begin
      ss_cnt <= '0;
      ss_level <= 3'h0;
    end else if (!ss_done) begin
      if (ss_cnt == SS_W'(SS_STEP_CYCLES - 1)) begin
        ss_cnt <= '0;
        ss_level <= ss_level + 3'h1; // [R9] [R17]
      end else begin
        ss_cnt <= ss_cnt + SS_W'(1);
      end
    end
  end

  // Limit code to the current-sense comparator reference
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cs_limit_mv_o <= LIM_START_MV;
    end else begin
      cs_limit_mv_o <= LIM_START_MV + LIM_STEP_MV * {7'h00, ss_level}; // [R10]
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_VALLEY_LSB +: 3] = valley;
    status_word[ST_CROSS_LSB +: 3] = cross_count;
    status_word[ST_LEVEL_LSB +: 3] = ss_level;
    status_word[ST_SSDONE_BIT] = ss_done;
    status_word[ST_RUN_BIT] = running;
    status_word[ST_GATE_BIT] = gate_drive_o;
    status_word[ST_CHARGE_BIT] = charge_cell_en_o;
  end

  assign s_axi_arready = !s_axi_rvalid;

  // One read in flight; unmapped addresses answer SLVERR with zero data
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr[7:2] == OFS_CTRL[7:2]) begin
        s_axi_rdata <= ctrl;
      end else if (s_axi_araddr[7:2] == OFS_STATUS[7:2]) begin
        s_axi_rdata <= status_word;
      end else if (s_axi_araddr[7:2] == OFS_LIMIT[7:2]) begin
        s_axi_rdata <= {22'h000000, cs_limit_mv_o};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : vcfr_top
